// ### hdl/smpc_top.sv
// The address map and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/100ps
// What this block does
// [RULE1] Sync read capture delayed 0 to 3 memory cycles, per field.
// [RULE2] Sync write data driven 0 to 3 memory cycles late, per field.
// [RULE3] Chip select ends after command, or follows output enable when set.
// [RULE4] Strobe pin: address strobe plus deselect, or read enable without; the code strobes it one cycle on reads and writes in both modes.
// [RULE5] Sync accesses timed to forwarded clock a or b, per clock select.
// [RULE6] Sync accesses use shared pins as strobe, output enable, write enable.
// [RULE7] SDRAM uses shared pins as column strobe, row strobe, write enable.
// [RULE8] Async uses shared pins as output enable, read strobe, write strobe.
// [RULE9] SDRAM bank on address 21..13, column on 11..2, address 12 low.
// [RULE10] Sync read data taken at rising edge of the selected memory clock.
// [RULE11] SDRAM commands and capture always timed to forwarded clock a.
module smpc_top
  import smpc_pkg::*;
#(
  parameter int ASYNC_STB = SMPC_ASYNC_STB,
  parameter int CAS_LAT = SMPC_CAS_LAT
) (
  // System clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hready_i,
  input wire logic [31:0] hwdata_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Link clock
  input wire logic lk_clk_i,
  // Memory pins
  output logic mem_clock_out_a_o,
  output logic mem_clock_out_b_o,
  output logic space_chip_select_n_o,
  output logic [3:0] byte_lane_enable_n_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic addr_strobe_or_read_en_n_o,
  output logic sync_output_enable_n_o,
  output logic sync_write_enable_n_o,
  input wire logic [31:0] data_i,
  output logic [31:0] data_o,
  output logic data_oe_o
);

  // System domain state
  logic ap_wr_q;
  logic [7:0] wa_q;
  logic [31:0] rd_mux;
  logic [CTRL_W-1:0] ctrl_q;
  logic [ADDR_W-1:0] areg_q;
  logic [31:0] wdat_q;
  logic [31:0] rdat_c_q;
  logic [2:0] op_c_q;
  logic [3:0] be_c_q;
  logic busy_q;
  logic done_q;
  logic req_tgl_q;
  logic done_seen_q;
  logic done_s;
  logic ap_valid;
  logic wr_cmd;
  logic cmd_ok;
  logic done_evt;

  // Link domain state
  smpc_state_t st_q;
  smpc_op_t eop_q;
  logic lk_rst;
  logic req_s;
  logic req_seen_q;
  logic done_tgl_q;
  logic [2:0] cnt_q;
  logic [2:0] hstep_q;
  logic [1:0] rl_q;
  logic [1:0] wl_q;
  logic cext_q;
  logic sfn_q;
  logic use_b_q;
  logic [31:0] rdat_l_q;
  logic rise_a;
  logic rise_b;
  logic pend;
  logic new_sync;
  logic step_new;
  logic step_cur;
  logic is_sync;
  logic is_async;
  logic is_rd;
  logic cap;

  assign ap_valid = hsel_i & hready_i & htrans_i[1];
  assign wr_cmd = ap_wr_q & (wa_q == SMPC_CMD_OFS);
  assign cmd_ok = hwdata_i[CMD_OP_LSB +: 3] != 3'h0 &&
                  hwdata_i[CMD_OP_LSB +: 3] != 3'h7;
  assign done_evt = done_s != done_seen_q;

  // Bus address phase and answer
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ap_wr_q <= 1'b0;
      wa_q <= 8'h00;
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      ap_wr_q <= ap_valid & hwrite_i;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      if (ap_valid) begin
        wa_q <= haddr_i[7:0];
      end
      if (ap_valid && !hwrite_i) begin
        hrdata_o <= rd_mux;
      end
    end
  end

  always_comb begin
    case (haddr_i[7:0])
      SMPC_CTRL_OFS: rd_mux = {25'h0, ctrl_q};
      SMPC_CMD_OFS: rd_mux = {24'h0, be_c_q, 1'b0, op_c_q};
      SMPC_ADDR_OFS: rd_mux = {12'h0, areg_q};
      SMPC_WDATA_OFS: rd_mux = wdat_q;
      SMPC_RDATA_OFS: rd_mux = rdat_c_q;
      SMPC_STAT_OFS: rd_mux = {30'h0, done_q, busy_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Setup registers, frozen while an access runs
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_q <= CTRL_RST;
      areg_q <= '0;
      wdat_q <= 32'h0000_0000;
    end else if (ap_wr_q && !busy_q) begin
      case (wa_q)
        SMPC_CTRL_OFS: ctrl_q <= hwdata_i[CTRL_W-1:0];
        SMPC_ADDR_OFS: areg_q <= hwdata_i[ADDR_W-1:0];
        SMPC_WDATA_OFS: wdat_q <= hwdata_i;
        default: ;
      endcase
    end
  end

  // Command launch and completion
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      op_c_q <= OP_NONE;
      be_c_q <= CMD_BE_RST;
      busy_q <= 1'b0;
      req_tgl_q <= 1'b0;
      done_seen_q <= 1'b0;
      rdat_c_q <= 32'h0000_0000;
    end else begin
      if (wr_cmd && !busy_q && cmd_ok) begin
        op_c_q <= hwdata_i[CMD_OP_LSB +: 3];
        be_c_q <= hwdata_i[CMD_BE_LSB +: 4];
        busy_q <= 1'b1;
        req_tgl_q <= ~req_tgl_q;
      end else if (done_evt) begin
        busy_q <= 1'b0;
      end
      if (done_evt) begin
        done_seen_q <= done_s;
        rdat_c_q <= rdat_l_q;
      end
    end
  end

  // Done flag; completion wins over a clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      done_q <= 1'b0;
    end else if (done_evt) begin
      done_q <= 1'b1;
    end else if ((ap_wr_q && wa_q == SMPC_STAT_OFS &&
                  hwdata_i[STAT_DONE_BIT]) ||
                 (wr_cmd && !busy_q && cmd_ok)) begin
      done_q <= 1'b0;
    end
  end

  smpc_sync #(.W(2)) u_lk_sync (
    .clk_i(lk_clk_i),
    .d_i({srst_i, req_tgl_q}),
    .q_o({lk_rst, req_s})
  );

  smpc_sync #(.W(1)) u_sys_sync (
    .clk_i(clk_i),
    .d_i(done_tgl_q),
    .q_o(done_s)
  );

  smpc_clk_fwd u_clk_fwd (
    .clk_i(lk_clk_i),
    .rst_i(lk_rst),
    .clk_a_o(mem_clock_out_a_o),
    .clk_b_o(mem_clock_out_b_o),
    .rise_a_o(rise_a),
    .rise_b_o(rise_b)
  );

  assign pend = req_s != req_seen_q;
  assign new_sync = op_c_q == OP_SRD || op_c_q == OP_SWR;
  assign step_new = (new_sync && ctrl_q[CTRL_CLK_BIT]) ?
                    rise_b : rise_a; // RULE5 RULE11
  assign step_cur = use_b_q ? rise_b : rise_a; // RULE5 RULE11
  assign is_sync = eop_q == OP_SRD || eop_q == OP_SWR;
  assign is_async = eop_q == OP_ARD || eop_q == OP_AWR;
  assign is_rd = eop_q == OP_SRD || eop_q == OP_DRD || eop_q == OP_ARD;
  assign cap = st_q == ST_WAIT && step_cur && cnt_q == 3'h0 && is_rd;

  // Access engine and memory pins
  always_ff @(posedge lk_clk_i) begin
    if (lk_rst) begin
      st_q <= ST_IDLE;
      eop_q <= OP_NONE;
      req_seen_q <= 1'b0;
      done_tgl_q <= 1'b0;
      cnt_q <= 3'h0;
      rl_q <= 2'h0;
      wl_q <= 2'h0;
      cext_q <= 1'b0;
      sfn_q <= 1'b0;
      use_b_q <= 1'b0;
      rdat_l_q <= 32'h0000_0000;
      space_chip_select_n_o <= 1'b1;
      byte_lane_enable_n_o <= 4'hF;
      addr_o <= '0;
      addr_strobe_or_read_en_n_o <= 1'b1;
      sync_output_enable_n_o <= 1'b1;
      sync_write_enable_n_o <= 1'b1;
      data_o <= 32'h0000_0000;
      data_oe_o <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (pend && step_new) begin
            req_seen_q <= req_s;
            eop_q <= smpc_op_t'(op_c_q);
            rl_q <= ctrl_q[CTRL_RL_LSB +: 2];
            wl_q <= ctrl_q[CTRL_WL_LSB +: 2];
            cext_q <= ctrl_q[CTRL_CEXT_BIT];
            sfn_q <= ctrl_q[CTRL_SFN_BIT];
            use_b_q <= new_sync & ctrl_q[CTRL_CLK_BIT];
            space_chip_select_n_o <= 1'b0;
            byte_lane_enable_n_o <= ~be_c_q;
            addr_o <= areg_q;
            data_o <= wdat_q;
            st_q <= ST_WAIT;
            case (op_c_q)
              OP_SRD: begin
                addr_strobe_or_read_en_n_o <= 1'b0; // RULE4 RULE6
                sync_output_enable_n_o <= 1'b0; // RULE6
                cnt_q <= {1'b0, ctrl_q[CTRL_RL_LSB +: 2]}; // RULE1
              end
              OP_SWR: begin
                addr_strobe_or_read_en_n_o <= 1'b0; // RULE4 RULE6
                sync_write_enable_n_o <= 1'b0; // RULE6
                cnt_q <= {1'b0, ctrl_q[CTRL_WL_LSB +: 2]}; // RULE2
                data_oe_o <= ctrl_q[CTRL_WL_LSB +: 2] == 2'h0; // RULE2
              end
              OP_DRD: begin
                addr_strobe_or_read_en_n_o <= 1'b0; // RULE7
                addr_o <= {areg_q[ADDR_BANK_LSB +: BANK_W], 1'b0,
                           areg_q[COL_W-1:0]}; // RULE9
                cnt_q <= 3'(CAS_LAT - 1);
              end
              OP_DWR: begin
                addr_strobe_or_read_en_n_o <= 1'b0; // RULE7
                sync_write_enable_n_o <= 1'b0; // RULE7
                addr_o <= {areg_q[ADDR_BANK_LSB +: BANK_W], 1'b0,
                           areg_q[COL_W-1:0]}; // RULE9
                data_oe_o <= 1'b1;
                cnt_q <= 3'h0;
              end
              OP_ARD: begin
                sync_output_enable_n_o <= 1'b0; // RULE8
                addr_strobe_or_read_en_n_o <= 1'b0; // RULE8
                cnt_q <= 3'(ASYNC_STB - 1);
              end
              OP_AWR: begin
                sync_write_enable_n_o <= 1'b0; // RULE8
                data_oe_o <= 1'b1;
                cnt_q <= 3'(ASYNC_STB - 1);
              end
              default: ;
            endcase
          end
        end
        ST_WAIT: begin
          if (step_cur) begin
            if (!is_async) begin
              addr_strobe_or_read_en_n_o <= 1'b1;
              sync_write_enable_n_o <= 1'b1;
              if (!(is_sync && cext_q && !sync_output_enable_n_o)) begin
                space_chip_select_n_o <= 1'b1; // RULE3
              end
            end
            if (cnt_q != 3'h0) begin
              cnt_q <= cnt_q - 3'h1;
              if (eop_q == OP_SWR && cnt_q == 3'h1) begin
                data_oe_o <= 1'b1; // RULE2
              end
            end else begin
              if (is_rd) begin
                rdat_l_q <= data_i; // RULE1 RULE10
              end
              data_oe_o <= 1'b0;
              sync_output_enable_n_o <= 1'b1;
              addr_strobe_or_read_en_n_o <= 1'b1;
              sync_write_enable_n_o <= 1'b1;
              space_chip_select_n_o <= 1'b1; // RULE3
              st_q <= (is_sync && !sfn_q) ? ST_DESEL : ST_DONE; // RULE4
            end
          end
        end
        ST_DESEL: begin
          if (step_cur) begin
            st_q <= ST_DONE; // RULE4
          end
        end
        ST_DONE: begin
          done_tgl_q <= ~done_tgl_q;
          st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Memory cycles since the command
  always_ff @(posedge lk_clk_i) begin
    if (lk_rst || st_q == ST_IDLE) begin
      hstep_q <= 3'h0;
    end else if (step_cur && hstep_q != 3'h7) begin
      hstep_q <= hstep_q + 3'h1;
    end
  end

  default clocking dcb @(posedge lk_clk_i);
  endclocking
  default disable iff (lk_rst);

  sequence cs_start_s;
    $fell(space_chip_select_n_o);
  endsequence

  rd_latency_a: assert property ( // RULE1 RULE10
    cap && eop_q == OP_SRD |-> hstep_q == {1'b0, rl_q})
    else $error("sync read captured at wrong latency");

  wr_latency_a: assert property ( // RULE2
    $rose(data_oe_o) && eop_q == OP_SWR |-> hstep_q == {1'b0, wl_q})
    else $error("sync write data at wrong latency");

  cs_short_a: assert property ( // RULE3
    st_q == ST_WAIT && is_sync && !cext_q && hstep_q != 3'h0
    |-> space_chip_select_n_o)
    else $error("chip select held past command");

  cs_extend_a: assert property ( // RULE3
    st_q == ST_WAIT && is_sync && cext_q && !sync_output_enable_n_o
    |-> !space_chip_select_n_o)
    else $error("chip select dropped while output enable active");

  desel_cycle_a: assert property ( // RULE4
    st_q == ST_DESEL
    |-> space_chip_select_n_o && addr_strobe_or_read_en_n_o && !sfn_q)
    else $error("bad deselect cycle");

  // Past value taken per clock, not through the select
  sync_clock_a: assert property ( // RULE5
    cs_start_s |-> (use_b_q ? $rose(mem_clock_out_b_o)
                            : $rose(mem_clock_out_a_o)))
    else $error("access not aligned to selected memory clock");

  sync_pins_a: assert property ( // RULE6
    !sync_write_enable_n_o && eop_q == OP_SWR
    |-> sync_output_enable_n_o && !addr_strobe_or_read_en_n_o)
    else $error("sync write pin use wrong");

  sdram_cmd_a: assert property ( // RULE7 RULE9
    st_q == ST_WAIT && hstep_q == 3'h0 &&
    (eop_q == OP_DRD || eop_q == OP_DWR)
    |-> sync_output_enable_n_o && !addr_strobe_or_read_en_n_o &&
    sync_write_enable_n_o == (eop_q == OP_DRD) && !addr_o[COL_W])
    else $error("sdram command pins wrong");

  async_pins_a: assert property ( // RULE8
    !addr_strobe_or_read_en_n_o && eop_q == OP_ARD && st_q == ST_WAIT
    |-> !sync_output_enable_n_o && !space_chip_select_n_o)
    else $error("async read select signals wrong");

  sdram_clock_a: assert property ( // RULE11
    cs_start_s ##0 (eop_q == OP_DRD || eop_q == OP_DWR)
    |-> $rose(mem_clock_out_a_o) && !use_b_q)
    else $error("sdram not timed to clock a");

endmodule

// ### hdl/smpc_pkg.sv
package smpc_pkg;

  // Register byte offsets
  localparam logic [7:0] SMPC_CTRL_OFS = 8'h00;
  localparam logic [7:0] SMPC_CMD_OFS = 8'h04;
  localparam logic [7:0] SMPC_ADDR_OFS = 8'h08;
  localparam logic [7:0] SMPC_WDATA_OFS = 8'h0C;
  localparam logic [7:0] SMPC_RDATA_OFS = 8'h10;
  localparam logic [7:0] SMPC_STAT_OFS = 8'h14;

  // Control fields
  localparam int CTRL_RL_LSB = 0;
  localparam int CTRL_WL_LSB = 2;
  localparam int CTRL_CEXT_BIT = 4;
  localparam int CTRL_SFN_BIT = 5;
  localparam int CTRL_CLK_BIT = 6;
  localparam int CTRL_W = 7;
  localparam logic [6:0] CTRL_RST = 7'h00;

  // Command fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BE_LSB = 4;
  localparam logic [3:0] CMD_BE_RST = 4'hF;

  // Status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  // Address fields and pin positions
  localparam int ADDR_W = 20;
  localparam int ADDR_BANK_LSB = 10;
  localparam int BANK_W = 9;
  localparam int COL_W = 10;

  // Timing counts in memory clock cycles
  localparam int SMPC_CAS_LAT = 3;
  localparam int SMPC_ASYNC_STB = 2;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_SRD = 3'h1,
    OP_SWR = 3'h2,
    OP_DRD = 3'h3,
    OP_DWR = 3'h4,
    OP_ARD = 3'h5,
    OP_AWR = 3'h6
  } smpc_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DESEL = 2'b11,
    ST_DONE = 2'b10
  } smpc_state_t;

endpackage

// ### hdl/smpc_sync.sv
`timescale 1ns/100ps
module smpc_sync #(
  parameter int W = 1
) (
  // Clock
  input wire logic clk_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  // Two-stage synchroniser
  always_ff @(posedge clk_i) begin
    meta_q <= d_i;
    q_o <= meta_q;
  end

endmodule

// ### hdl/smpc_clk_fwd.sv
`timescale 1ns/100ps
module smpc_clk_fwd (
  // Link clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Forwarded clocks
  output logic clk_a_o,
  output logic clk_b_o,
  // Next edge raises the clock
  output logic rise_a_o,
  output logic rise_b_o
);

  logic div_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_a_o <= 1'b0;
      clk_b_o <= 1'b0;
      div_q <= 1'b0;
    end else begin
      clk_a_o <= ~clk_a_o;
      div_q <= ~div_q;
      clk_b_o <= clk_b_o ^ div_q;
    end
  end

  assign rise_a_o = ~clk_a_o;
  assign rise_b_o = div_q & ~clk_b_o;

endmodule

// ### dv/smpc_mem_model.sv
`timescale 1ns/100ps
module smpc_mem_model (
  // Memory clocks and timing selection
  input wire logic clk_a_i,
  input wire logic clk_b_i,
  input wire logic sel_i,
  input wire logic [2:0] lat_i,
  // Device pins
  input wire logic cs_n_i,
  input wire logic [3:0] be_n_i,
  input wire logic [19:0] addr_i,
  input wire logic stb_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [31:0] wdata_i,
  input wire logic wdata_oe_i,
  output logic [31:0] rdata_o,
  // Observations
  output logic [2:0] cmd_pins_o,
  output logic [19:0] cmd_addr_o,
  output logic [3:0] cmd_be_n_o,
  output logic [3:0] cs_cnt_o,
  output logic [31:0] wr_data_o,
  output logic [3:0] wr_lat_o
);
  logic mclk;
  logic armed = 1'b1;
  logic rd = 1'b0;
  logic seen = 1'b1;
  logic [3:0] k = 4'hE;
  initial rdata_o = 32'h0;
  assign mclk = sel_i ? clk_b_i : clk_a_i;
  // Sampled half a memory cycle after the pins change
  always @(negedge mclk) begin
    if (k < 4'hE) k = k + 4'h1;
    if (!cs_n_i && armed && (!stb_n_i || !we_n_i)) begin
      armed = 1'b0;
      k = 4'h0;
      rd = we_n_i;
      seen = we_n_i;
      cmd_pins_o = {stb_n_i, oe_n_i, we_n_i};
      cmd_addr_o = addr_i;
      cmd_be_n_o = be_n_i;
      cs_cnt_o = 4'h0;
    end
    if (cs_n_i) armed = 1'b1;
    else if (!armed) cs_cnt_o = cs_cnt_o + 4'h1;
    if (!seen && wdata_oe_i) begin
      seen = 1'b1;
      wr_data_o = wdata_i;
      wr_lat_o = k;
    end
    // Valid only around the capture edge, toggling otherwise
    if (rd && k == {1'b0, lat_i} - 4'h1) begin
      rdata_o = {12'hC3A, cmd_addr_o};
    end else begin
      rdata_o = ~rdata_o;
    end
    if (k == {1'b0, lat_i}) rd = 1'b0;
  end
endmodule

// ### dv/sync_memory_port_control_bench.sv
`timescale 1ns/100ps
module sync_memory_port_control_bench;
  import smpc_pkg::*;
  logic clk_i = 0, lk_clk_i = 0, srst_i = 1, hsel_i = 0, hwrite_i = 0;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, data_i, data_o;
  logic [1:0] htrans_i = 0;
  logic hreadyout_o, hresp_o, ca, cb, cs_n, stb_n, oe_n, we_n, data_oe;
  logic [3:0] be_n, cmd_be_n, cs_cnt, wr_lat;
  logic [19:0] addr, cmd_addr, a, epa;
  logic [2:0] cmd_pins, mlat = 3'h1;
  logic [31:0] wr_data, wd;
  logic msel = 0;
  int n_mismatch = 0, comparisons = 0;
  initial forever #2 clk_i = ~clk_i;
  initial begin
    #37.3;
    forever #62.5 lk_clk_i = ~lk_clk_i;
  end
  smpc_top smpc_top_inst (.clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hsize_i(3'b010), .hready_i(hreadyout_o), .hwdata_i(hwdata_i),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .lk_clk_i(lk_clk_i), .mem_clock_out_a_o(ca), .mem_clock_out_b_o(cb),
    .space_chip_select_n_o(cs_n), .byte_lane_enable_n_o(be_n),
    .addr_o(addr), .addr_strobe_or_read_en_n_o(stb_n),
    .sync_output_enable_n_o(oe_n), .sync_write_enable_n_o(we_n),
    .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe));
  smpc_mem_model smpc_mem_model_inst (.clk_a_i(ca), .clk_b_i(cb),
    .sel_i(msel), .lat_i(mlat), .cs_n_i(cs_n), .be_n_i(be_n),
    .addr_i(addr), .stb_n_i(stb_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .wdata_i(data_o), .wdata_oe_i(data_oe), .rdata_o(data_i),
    .cmd_pins_o(cmd_pins), .cmd_addr_o(cmd_addr), .cmd_be_n_o(cmd_be_n),
    .cs_cnt_o(cs_cnt), .wr_data_o(wr_data), .wr_lat_o(wr_lat));
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) begin
      n++;
      if (n == 100) begin
        n_mismatch++;
        close_out;
      end
      @(posedge clk_i);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] ad,
                     input logic [31:0] d, output logic [31:0] q);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, ad};
    htrans_i <= 2'b10;
    hwrite_i <= w;
    wait_rdy;
    htrans_i <= 2'b00;
    hwdata_i <= d;
    wait_rdy;
    q = hrdata_o;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, ad, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, ad, 32'h0, q);
    chk(q, e);
    chk({31'h0, hresp_o}, 32'h0);
  endtask
  task automatic acc(input logic [6:0] ctrl, input logic [2:0] op,
                     input logic [3:0] be, input logic sel,
                     input logic [2:0] lat);
    int n;
    logic [31:0] q;
    msel <= sel;
    mlat <= lat;
    wr(SMPC_CTRL_OFS, {25'h0, ctrl});
    wr(SMPC_ADDR_OFS, {12'h0, a});
    wr(SMPC_WDATA_OFS, wd);
    wr(SMPC_CMD_OFS, {24'h0, be, 1'b0, op});
    n = 0;
    q = 32'h1;
    while (q[1:0] !== 2'b10) begin
      bus(1'b0, SMPC_STAT_OFS, 32'h0, q);
      n++;
      if (n == 2000) begin
        n_mismatch++;
        close_out;
      end
    end
    chk({28'h0, cmd_be_n}, {28'h0, ~be});
  endtask
  initial begin
    #200000;
    n_mismatch++;
    close_out;
  end
  initial begin
    repeat (150) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (200) @(posedge clk_i);
    rd_chk(SMPC_CTRL_OFS, 32'h0);
    rd_chk(SMPC_STAT_OFS, 32'h0);
    rd_chk(8'h20, 32'h0);
    wr(SMPC_CTRL_OFS, 32'h7F);
    rd_chk(SMPC_CTRL_OFS, 32'h7F);
    $display("register test done");
    wd = 32'h0;
    for (int i = 0; i < 4; i++) begin
      a = 20'h1A5C0 + 20'(i);
      acc({i[0], i[1], i[0], 2'b00, i[1:0]}, OP_SRD, 4'h1 << i, i[0],
          3'(i + 1));
      rd_chk(SMPC_RDATA_OFS, {12'hC3A, a});
      chk({29'h0, cmd_pins}, 32'h1);
      chk({28'h0, cs_cnt}, i[0] ? 32'(i + 1) : 32'h1);
    end
    $display("sync read test done");
    for (int i = 0; i < 4; i++) begin
      wd = 32'h5EED0000 + 32'(i);
      acc({i[1], 2'b00, i[1:0], 2'b00}, OP_SWR, 4'h8 >> i, i[1], 3'h1);
      chk(wr_data, wd);
      chk({28'h0, wr_lat}, 32'(i));
      chk({29'h0, cmd_pins}, 32'h2);
    end
    $display("sync write test done");
    for (int j = 0; j < 4; j++) begin
      a = (j < 2) ? {1'b0, 9'h1A5, 10'h2C3} : 20'h3C00F + 20'(j);
      epa = (j < 2) ? {a[18:10], 1'b0, a[9:0]} : a;
      wd = 32'hA0B0C0D0 + 32'(j);
      acc(7'h40, 3'(j + 3), 4'hF, 1'b0,
          (j < 2) ? 3'(SMPC_CAS_LAT) : 3'(SMPC_ASYNC_STB));
      if (j < 2) chk({12'h0, cmd_addr}, {12'h0, epa});
      // Pins strobe, output enable, write enable per op, three bits each
      chk({29'h0, cmd_pins},
          32'(12'h68E >> (3 * (3 - j))) & 32'h7);
      if (j[0] == 1'b0) rd_chk(SMPC_RDATA_OFS, {12'hC3A, epa});
      else chk(wr_data, wd);
    end
    rd_chk(SMPC_STAT_OFS, 32'h2);
    wr(SMPC_STAT_OFS, 32'h2);
    rd_chk(SMPC_STAT_OFS, 32'h0);
    $display("sdram and async test done");
    close_out;
  end
endmodule
